// ==== hdl/dtc_map.svh ====
// register map, field positions and reset values for the dual timer/counter
`ifndef DTC_MAP_SVH
`define DTC_MAP_SVH
`define DTC_ADDR_MODE     8'h89
`define DTC_ADDR_CTRL     8'h88
`define DTC_ADDR_ZERO_LOW  8'h8A
`define DTC_ADDR_ONE_LOW   8'h8B
`define DTC_ADDR_ZERO_HIGH 8'h8C
`define DTC_ADDR_ONE_HIGH  8'h8D
`define DTC_MODE_RESET    8'h00
`define DTC_CTRL_RESET    8'h00
`define DTC_BYTE_RESET    8'h00
`define DTC_BIT_ONE_GATE    7
`define DTC_BIT_ONE_SRC     6
`define DTC_BIT_ONE_MODE_H  5
`define DTC_BIT_ONE_MODE_L  4
`define DTC_BIT_ZERO_GATE   3
`define DTC_BIT_ZERO_SRC    2
`define DTC_BIT_ZERO_MODE_H 1
`define DTC_BIT_ZERO_MODE_L 0
`define DTC_BIT_ONE_OVF     7
`define DTC_BIT_ONE_RUN     6
`define DTC_BIT_ZERO_OVF    5
`define DTC_BIT_ZERO_RUN    4
`define DTC_PRESCALE_MAX  5'h1F
`define DTC_BYTE_MAX      8'hFF
`endif

// ==== hdl/dtc_pkg.sv ====
// types shared by the dual timer/counter files
`default_nettype none
package dtc_pkg;
	typedef enum logic [1:0] {
		DTC_MODE_THIRTEEN = 2'b00,
		DTC_MODE_SIXTEEN  = 2'b01,
		DTC_MODE_RELOAD   = 2'b10,
		DTC_MODE_SPLIT    = 2'b11
	} dtc_mode_e;
	typedef struct packed {
		logic       gate;
		logic       source;
		dtc_mode_e  mode;
	} dtc_cfg_s;
	typedef struct packed {
		logic       count_pin;
		logic       gate_pin;
	} dtc_pins_s;
endpackage
`default_nettype wire

// ==== hdl/dtc_pin_sync.sv ====
// three-stage synchroniser with agreement filter and falling-edge detect
`default_nettype none
module dtc_pin_sync #(
	parameter int WIDTH = 2
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] pin,
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] fall
);
	logic [WIDTH-1:0] stage_a;
	logic [WIDTH-1:0] stage_b;
	logic [WIDTH-1:0] stage_c;

	// refuse a width that leaves no pin to watch
	if (WIDTH < 1) begin : g_width_check
		$error("dtc_pin_sync: WIDTH must be at least 1");
	end

	// first stage feeds only the second, to keep metastability contained
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stage_a <= '0;
			stage_b <= '0;
			stage_c <= '0;
		end else begin
			stage_a <= pin;
			stage_b <= stage_a;
			stage_c <= stage_b;
		end
	end

	// a level counts once stages two and three agree
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			level <= '0;
			fall  <= '0;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				fall[i] <= 1'b0;
				if (stage_b[i] == stage_c[i]) begin
					level[i] <= stage_c[i];
					fall[i]  <= level[i] & ~stage_c[i]; // high sample then low sample
				end
			end
		end
	end
endmodule
`default_nettype wire

// ==== hdl/dtc_timer_pair.sv ====
// dual timer/counter: mode, control and count byte registers on the sfr port
//
// Notes on behaviour
// - timer operation adds one to the low byte every core clock.
// - counter operation counts a high sample followed by a low sample.
// - a pin falling edge needs four core clocks, two samples a level, so quarter-rate maximum.
// - timer one gate bit makes its gate pin qualify the run bit.
// - timer one source bit picks pin edges or core clocks.
// - mode 00 is high byte behind a five-bit low-byte prescaler.
// - mode 01 cascades both bytes into one sixteen-bit counter.
// - mode 10 counts low byte, reloading it from high byte on overflow.
// - timer one in mode 11 holds its count registers still.
// - timer zero mode 11 splits; high byte timed under timer one run.
// - timer zero gate bit makes its gate pin qualify the run bit.
// - timer zero source bit picks pin edges or core clocks.
// - mode register at 89h, resets to zero, whole-byte access only.
// - overflow flags set on overflow, cleared on vector acknowledge.
// - run bits in control register are set and cleared by software.
// - thirteen-bit count ignores the upper three low-byte bits.
// - reload leaves high byte alone; run does not clear counts.
`include "dtc_map.svh"
`default_nettype none
module dtc_timer_pair (
	// clock and reset
	input  wire logic                 MCLK,
	input  wire logic                 RST_B,
	// special-function register port
	input  wire logic [7:0]           SFR_ADDR,
	input  wire logic                 SFR_WR,
	input  wire logic [7:0]           SFR_WDATA,
	input  wire logic                 SFR_RD,
	output logic      [7:0]           SFR_RDATA,
	output logic                      SFR_HIT,
	// interrupt vector acknowledge
	input  wire logic                 ACK_ZERO,
	input  wire logic                 ACK_ONE,
	// external pins, asynchronous
	input  wire dtc_pkg::dtc_pins_s   PINS_ZERO,
	input  wire dtc_pkg::dtc_pins_s   PINS_ONE,
	// overflow flags towards the interrupt controller
	output logic                      TIMER_ZERO_OVERFLOW,
	output logic                      TIMER_ONE_OVERFLOW
);
	import dtc_pkg::*;

	logic [7:0] timer_mode_config;
	logic [7:0] timer_control_flags;
	logic [7:0] timer_zero_low_byte;
	logic [7:0] timer_zero_high_byte;
	logic [7:0] timer_one_low_byte;
	logic [7:0] timer_one_high_byte;
	dtc_cfg_s   cfg_zero;
	dtc_cfg_s   cfg_one;
	logic [3:0] pin_level;
	logic [3:0] pin_fall;
	logic       timer_zero_run;
	logic       timer_one_run;
	logic       tick_zero;
	logic       tick_one;
	logic       tick_zero_high;
	logic       wr_mode;
	logic       wr_ctrl;
	logic       wr_t0l;
	logic       wr_t0h;
	logic       wr_t1l;
	logic       wr_t1h;
	logic [7:0] next_t0l;
	logic [7:0] next_t0h;
	logic [7:0] next_t1l;
	logic [7:0] next_t1h;
	logic       ovf_zero;
	logic       ovf_one;
	logic       ovf_split;

	// address decode, used for the write strobes; the read mux decodes with a case
	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		return a == r;
	endfunction

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	// order: count zero, gate zero, count one, gate one
	dtc_pin_sync #(
		.WIDTH (4)
	) u_sync (
		.clk   (MCLK),
		.rst_b (RST_B),
		.pin   ({PINS_ONE.gate_pin, PINS_ONE.count_pin, PINS_ZERO.gate_pin, PINS_ZERO.count_pin}),
		.level (pin_level),
		.fall  (pin_fall)
	);

	// ---------------------------------------------------------------
	// register writes
	// ---------------------------------------------------------------
	assign wr_mode = SFR_WR & hit(SFR_ADDR, `DTC_ADDR_MODE);
	assign wr_ctrl = SFR_WR & hit(SFR_ADDR, `DTC_ADDR_CTRL);
	assign wr_t0l  = SFR_WR & hit(SFR_ADDR, `DTC_ADDR_ZERO_LOW);
	assign wr_t0h  = SFR_WR & hit(SFR_ADDR, `DTC_ADDR_ZERO_HIGH);
	assign wr_t1l  = SFR_WR & hit(SFR_ADDR, `DTC_ADDR_ONE_LOW);
	assign wr_t1h  = SFR_WR & hit(SFR_ADDR, `DTC_ADDR_ONE_HIGH);

	// mode register: byte-wide only, no bit addressing exists on this port
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			timer_mode_config <= `DTC_MODE_RESET;
		end else if (wr_mode) begin
			timer_mode_config <= SFR_WDATA;
		end
	end

	assign cfg_zero = dtc_cfg_s'({timer_mode_config[`DTC_BIT_ZERO_GATE], timer_mode_config[`DTC_BIT_ZERO_SRC],
		timer_mode_config[`DTC_BIT_ZERO_MODE_H], timer_mode_config[`DTC_BIT_ZERO_MODE_L]});
	assign cfg_one  = dtc_cfg_s'({timer_mode_config[`DTC_BIT_ONE_GATE], timer_mode_config[`DTC_BIT_ONE_SRC],
		timer_mode_config[`DTC_BIT_ONE_MODE_H], timer_mode_config[`DTC_BIT_ONE_MODE_L]});

	// control register: run bits by software, overflow flags by hardware;
	// a hardware set beats a same-cycle clear so no overflow is lost
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			timer_control_flags <= `DTC_CTRL_RESET;
		end else begin
			if (wr_ctrl) begin
				timer_control_flags <= SFR_WDATA;
			end
			if (ACK_ZERO) begin
				timer_control_flags[`DTC_BIT_ZERO_OVF] <= 1'b0;
			end
			if (ACK_ONE) begin
				timer_control_flags[`DTC_BIT_ONE_OVF] <= 1'b0;
			end
			if (ovf_zero) begin
				timer_control_flags[`DTC_BIT_ZERO_OVF] <= 1'b1;
			end
			if (ovf_one | ovf_split) begin
				timer_control_flags[`DTC_BIT_ONE_OVF] <= 1'b1;
			end
		end
	end

	assign timer_zero_run = timer_control_flags[`DTC_BIT_ZERO_RUN];
	assign timer_one_run  = timer_control_flags[`DTC_BIT_ONE_RUN];

	// ---------------------------------------------------------------
	// count enables
	// ---------------------------------------------------------------
	// gate pin qualifies the run bit only when gating is selected
	always_comb begin
		tick_zero = timer_zero_run & (~cfg_zero.gate | pin_level[1]);
		tick_zero = tick_zero & (cfg_zero.source ? pin_fall[0] : 1'b1);
		tick_one  = timer_one_run & (~cfg_one.gate | pin_level[3]);
		tick_one  = tick_one & (cfg_one.source ? pin_fall[2] : 1'b1);
		// split mode borrows timer one's run bit for the zero high byte
		tick_zero_high = timer_one_run;
	end

	// ---------------------------------------------------------------
	// timer zero next values
	// ---------------------------------------------------------------
	always_comb begin
		next_t0l = timer_zero_low_byte;
		next_t0h = timer_zero_high_byte;
		ovf_zero = 1'b0;
		unique case (cfg_zero.mode)
			DTC_MODE_THIRTEEN: begin
				if (tick_zero) begin
					// upper three low bits are left as they stand
					next_t0l[4:0] = timer_zero_low_byte[4:0] + 5'h01;
					if (timer_zero_low_byte[4:0] == `DTC_PRESCALE_MAX) begin
						next_t0h = timer_zero_high_byte + 8'h01;
						ovf_zero = (timer_zero_high_byte == `DTC_BYTE_MAX);
					end
				end
			end
			DTC_MODE_SIXTEEN: begin
				if (tick_zero) begin
					{next_t0h, next_t0l} = {timer_zero_high_byte, timer_zero_low_byte} + 16'h0001;
					ovf_zero = ({timer_zero_high_byte, timer_zero_low_byte} == 16'hFFFF);
				end
			end
			DTC_MODE_RELOAD: begin
				if (tick_zero) begin
					if (timer_zero_low_byte == `DTC_BYTE_MAX) begin
						next_t0l = timer_zero_high_byte;
						ovf_zero = 1'b1;
					end else begin
						next_t0l = timer_zero_low_byte + 8'h01;
					end
				end
			end
			DTC_MODE_SPLIT: begin
				if (tick_zero) begin
					next_t0l = timer_zero_low_byte + 8'h01;
					ovf_zero = (timer_zero_low_byte == `DTC_BYTE_MAX);
				end
				if (tick_zero_high) begin
					next_t0h = timer_zero_high_byte + 8'h01;
				end
			end
		endcase
	end

	// ---------------------------------------------------------------
	// timer one next values
	// ---------------------------------------------------------------
	always_comb begin
		next_t1l = timer_one_low_byte;
		next_t1h = timer_one_high_byte;
		ovf_one  = 1'b0;
		unique case (cfg_one.mode)
			DTC_MODE_THIRTEEN: begin
				if (tick_one) begin
					next_t1l[4:0] = timer_one_low_byte[4:0] + 5'h01;
					if (timer_one_low_byte[4:0] == `DTC_PRESCALE_MAX) begin
						next_t1h = timer_one_high_byte + 8'h01;
						ovf_one  = (timer_one_high_byte == `DTC_BYTE_MAX);
					end
				end
			end
			DTC_MODE_SIXTEEN: begin
				if (tick_one) begin
					{next_t1h, next_t1l} = {timer_one_high_byte, timer_one_low_byte} + 16'h0001;
					ovf_one = ({timer_one_high_byte, timer_one_low_byte} == 16'hFFFF);
				end
			end
			DTC_MODE_RELOAD: begin
				if (tick_one) begin
					if (timer_one_low_byte == `DTC_BYTE_MAX) begin
						next_t1l = timer_one_high_byte;
						ovf_one  = 1'b1;
					end else begin
						next_t1l = timer_one_low_byte + 8'h01;
					end
				end
			end
			DTC_MODE_SPLIT: begin
				// stopped: both bytes hold
				next_t1l = timer_one_low_byte;
				next_t1h = timer_one_high_byte;
			end
		endcase
	end

	// in split mode timer zero's high byte overflow sets timer one's flag
	assign ovf_split = (cfg_zero.mode == DTC_MODE_SPLIT) & tick_zero_high
		& (timer_zero_high_byte == `DTC_BYTE_MAX);

	// ---------------------------------------------------------------
	// count byte registers
	// ---------------------------------------------------------------
	// software writes override the count; run bits never clear counts
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			timer_zero_low_byte  <= `DTC_BYTE_RESET;
			timer_zero_high_byte <= `DTC_BYTE_RESET;
		end else begin
			timer_zero_low_byte  <= wr_t0l ? SFR_WDATA : next_t0l;
			timer_zero_high_byte <= wr_t0h ? SFR_WDATA : next_t0h;
		end
	end

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			timer_one_low_byte  <= `DTC_BYTE_RESET;
			timer_one_high_byte <= `DTC_BYTE_RESET;
		end else begin
			timer_one_low_byte  <= wr_t1l ? SFR_WDATA : next_t1l;
			timer_one_high_byte <= wr_t1h ? SFR_WDATA : next_t1h;
		end
	end

	// ---------------------------------------------------------------
	// read path
	// ---------------------------------------------------------------
	// read data registered; unmapped addresses read zero with no hit
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			SFR_RDATA <= 8'h00;
			SFR_HIT   <= 1'b0;
		end else begin
			SFR_HIT   <= 1'b0;
			SFR_RDATA <= 8'h00;
			if (SFR_RD) begin
				SFR_HIT <= 1'b1;
				unique case (SFR_ADDR)
					`DTC_ADDR_MODE:    SFR_RDATA <= timer_mode_config;
					`DTC_ADDR_CTRL:    SFR_RDATA <= timer_control_flags;
					`DTC_ADDR_ZERO_LOW:  SFR_RDATA <= timer_zero_low_byte;
					`DTC_ADDR_ZERO_HIGH: SFR_RDATA <= timer_zero_high_byte;
					`DTC_ADDR_ONE_LOW:   SFR_RDATA <= timer_one_low_byte;
					`DTC_ADDR_ONE_HIGH:  SFR_RDATA <= timer_one_high_byte;
					default:           SFR_HIT   <= 1'b0;
				endcase
			end
		end
	end

	assign TIMER_ZERO_OVERFLOW = timer_control_flags[`DTC_BIT_ZERO_OVF];
	assign TIMER_ONE_OVERFLOW  = timer_control_flags[`DTC_BIT_ONE_OVF];
endmodule
`default_nettype wire

// ==== verif/dtc_timer_pair_asserts.sv ====
// concurrent checks on the timer pair register port and flags
`default_nettype none
module dtc_timer_pair_asserts (
	// clock and reset
	input wire logic               MCLK,
	input wire logic               RST_B,
	// register port
	input wire logic [7:0]         SFR_ADDR,
	input wire logic               SFR_WR,
	input wire logic [7:0]         SFR_WDATA,
	input wire logic               SFR_RD,
	input wire logic [7:0]         SFR_RDATA,
	input wire logic               SFR_HIT,
	// acknowledge, pins and flags
	input wire logic               ACK_ZERO,
	input wire logic               ACK_ONE,
	input wire dtc_pkg::dtc_pins_s PINS_ZERO,
	input wire dtc_pkg::dtc_pins_s PINS_ONE,
	input wire logic               TIMER_ZERO_OVERFLOW,
	input wire logic               TIMER_ONE_OVERFLOW
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_B);
	wire logic mapped;
	wire logic ctrl_wr;
	// decode kept here so each property stays short
	assign mapped  = SFR_ADDR >= 8'h88 && SFR_ADDR <= 8'h8D;
	assign ctrl_wr = SFR_WR && SFR_ADDR == 8'h88;
	// ----------------------------------------
	// register port
	// ----------------------------------------
	hit_after_read_a: assert property (SFR_HIT |-> $past(SFR_RD) && $past(mapped))
		else $error("hit without mapped read");
	mapped_hit_a: assert property (SFR_RD && mapped |=> SFR_HIT)
		else $error("mapped read gave no hit");
	unmapped_zero_a: assert property (SFR_RD && !mapped |=> SFR_RDATA == 8'h00 && !SFR_HIT)
		else $error("unmapped read not zero");
	idle_zero_a: assert property (!SFR_RD |=> SFR_RDATA == 8'h00)
		else $error("read data without strobe");
	mode_readback_a: assert property ((SFR_WR && SFR_ADDR == 8'h89) ##1 !SFR_WR
		##1 (SFR_RD && SFR_ADDR == 8'h89 && !SFR_WR) |=> SFR_RDATA == $past(SFR_WDATA, 3))
		else $error("mode register readback wrong");
	// ----------------------------------------
	// overflow flags
	// ----------------------------------------
	flag_zero_hold_a: assert property (TIMER_ZERO_OVERFLOW && !ACK_ZERO && !ctrl_wr
		|=> TIMER_ZERO_OVERFLOW)
		else $error("timer zero flag lost");
	flag_one_fall_a: assert property ($fell(TIMER_ONE_OVERFLOW) |-> $past(ACK_ONE) || $past(ctrl_wr))
		else $error("timer one flag fell without cause");
	ctrl_sets_flag_a: assert property (ctrl_wr && SFR_WDATA[7] && SFR_WDATA[5]
		|=> TIMER_ONE_OVERFLOW && TIMER_ZERO_OVERFLOW)
		else $error("software flag write ignored");
	cover property ($rose(TIMER_ZERO_OVERFLOW) && !$past(ctrl_wr));
	cover property ($rose(TIMER_ONE_OVERFLOW) && !$past(ctrl_wr));
	cover property (SFR_HIT && SFR_RDATA != 8'h00);
endmodule
bind dtc_timer_pair dtc_timer_pair_asserts u_asserts (.MCLK(MCLK), .RST_B(RST_B), .SFR_ADDR(SFR_ADDR),
	.SFR_WR(SFR_WR), .SFR_WDATA(SFR_WDATA), .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA), .SFR_HIT(SFR_HIT),
	.ACK_ZERO(ACK_ZERO), .ACK_ONE(ACK_ONE), .PINS_ZERO(PINS_ZERO), .PINS_ONE(PINS_ONE),
	.TIMER_ZERO_OVERFLOW(TIMER_ZERO_OVERFLOW), .TIMER_ONE_OVERFLOW(TIMER_ONE_OVERFLOW));
`default_nettype wire

// ==== verif/dtc_pin_model.sv ====
// far-side model of the count and gate pins of both timers
`default_nettype none
module dtc_pin_model (
	// core clock
	input  wire logic               clk,
	// bench controls
	input  wire logic [1:0]         gate_lvl,
	input  wire logic [3:0]         pulses,
	input  wire logic               go,
	// pins into the block
	output wire dtc_pkg::dtc_pins_s pins_zero,
	output wire dtc_pkg::dtc_pins_s pins_one
);
	timeunit 1ns;
	timeprecision 1ns;
	logic cnt = 1'b1;
	// count pins rest high, as the pull-ups leave them
	assign pins_zero = {cnt, gate_lvl[0]};
	assign pins_one  = {cnt, gate_lvl[1]};
	// four cycles a level: beyond the minimum, so the input filter sees it
	always @(posedge clk) begin
		if (go) begin
			for (int i = 0; i < int'(pulses); i++) begin
				repeat (4) @(posedge clk);
				cnt <= 1'b0;
				repeat (4) @(posedge clk);
				cnt <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== verif/test_dual_timer_counter_mode_logic.sv ====
// self-checking bench for the dual timer/counter
`default_nettype none
module test_dual_timer_counter_mode_logic;
	timeunit 1ns;
	timeprecision 1ns;
	logic       mclk = 1'b0;
	logic       rst_b = 1'b0;
	logic       sfr_wr = 1'b0;
	logic       sfr_rd = 1'b0;
	logic       ack_zero = 1'b0;
	logic       ack_one = 1'b0;
	logic       go = 1'b0;
	logic [7:0] sfr_addr = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	logic [1:0] gate_lvl = 2'b00;
	logic [3:0] pulses = 4'h3;
	wire logic [7:0] sfr_rdata;
	wire logic       sfr_hit;
	wire logic [1:0] ovf;
	wire dtc_pkg::dtc_pins_s pins_zero;
	wire dtc_pkg::dtc_pins_s pins_one;
	int         failures = 0;
	int         checked = 0;
	always #10 mclk = ~mclk;
	dtc_timer_pair dut (.MCLK(mclk), .RST_B(rst_b), .SFR_ADDR(sfr_addr), .SFR_WR(sfr_wr),
		.SFR_WDATA(sfr_wdata), .SFR_RD(sfr_rd), .SFR_RDATA(sfr_rdata), .SFR_HIT(sfr_hit),
		.ACK_ZERO(ack_zero), .ACK_ONE(ack_one), .PINS_ZERO(pins_zero), .PINS_ONE(pins_one),
		.TIMER_ZERO_OVERFLOW(ovf[0]), .TIMER_ONE_OVERFLOW(ovf[1]));
	dtc_pin_model partner (.clk(mclk), .gate_lvl(gate_lvl), .pulses(pulses), .go(go),
		.pins_zero(pins_zero), .pins_one(pins_one));
	// ----------------------------------------
	// access tasks
	// ----------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		sfr_wr <= 1'b1;
		sfr_addr <= a;
		sfr_wdata <= d;
		@(posedge mclk);
		sfr_wr <= 1'b0;
	endtask
	// data lands one cycle after the strobe, so look 1 ns past that edge
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] mask);
		@(posedge mclk);
		sfr_rd <= 1'b1;
		sfr_addr <= a;
		@(posedge mclk);
		sfr_rd <= 1'b0;
		#1;
		chk(sfr_rdata & mask, exp);
		chk({7'h00, sfr_hit}, {7'h00, a >= 8'h88 && a <= 8'h8D});
	endtask
	task automatic load(input logic [7:0] m, l0, h0, l1, h1);
		wr(8'h89, m);
		wr(8'h8A, l0);
		wr(8'h8C, h0);
		wr(8'h8B, l1);
		wr(8'h8D, h1);
	endtask
	// run bits on for five edges; flags looked at after the third
	task automatic run(input logic [7:0] ctrl, input logic [1:0] flags);
		wr(8'h88, ctrl);
		repeat (3) @(posedge mclk);
		#1;
		chk({6'h00, ovf}, {6'h00, flags});
		wr(8'h88, 8'h00);
	endtask
	task automatic expect4(input logic [7:0] l0, h0, l1, h1, mask);
		rd(8'h8A, l0 & mask, mask);
		rd(8'h8C, h0, 8'hFF);
		rd(8'h8B, l1 & mask, mask);
		rd(8'h8D, h1, 8'hFF);
	endtask
	task automatic conclude();
		if (failures == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge mclk);
		rst_b <= 1'b1;
		for (int a = 8'h87; a <= 8'h8E; a++) begin
			rd(8'(a), 8'h00, 8'hFF);
		end
		wr(8'h89, 8'h55);
		rd(8'h89, 8'h55, 8'hFF);
		load(8'h01, 8'hFE, 8'hFF, 8'h00, 8'h00);
		run(8'h10, 2'b01);
		expect4(8'h03, 8'h00, 8'h00, 8'h00, 8'hFF);
		load(8'h00, 8'h00, 8'h00, 8'h1E, 8'hFF);
		run(8'h40, 2'b10);
		expect4(8'h00, 8'h00, 8'h03, 8'h00, 8'h1F);
		load(8'h02, 8'hFE, 8'h80, 8'h00, 8'h00);
		run(8'h10, 2'b01);
		expect4(8'h83, 8'h80, 8'h00, 8'h00, 8'hFF);
		// a write in mid-run replaces that cycle's increment: 00, 01, write 40, 41, 42
		load(8'h01, 8'h00, 8'h00, 8'h00, 8'h00);
		wr(8'h88, 8'h10);
		wr(8'h8A, 8'h40);
		wr(8'h88, 8'h00);
		expect4(8'h42, 8'h00, 8'h00, 8'h00, 8'hFF);
		// split high byte wraps from ff on timer one's run bit and raises timer one's flag
		load(8'h33, 8'h10, 8'hFE, 8'h55, 8'h66);
		run(8'h40, 2'b10);
		expect4(8'h10, 8'h03, 8'h55, 8'h66, 8'hFF);
		for (int g = 0; g < 2; g++) begin
			@(posedge mclk);
			gate_lvl <= 2'(3 * g);
			load(8'h99, 8'h00, 8'h10, 8'h00, 8'h20);
			run(8'h50, 2'b00);
			expect4(8'(5 * g), 8'h10, 8'(5 * g), 8'h20, 8'hFF);
		end
		// pin edges only: a core-clock count would pass 40 here
		load(8'h55, 8'h00, 8'h00, 8'h00, 8'h00);
		wr(8'h88, 8'h50);
		go <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
		repeat (40) @(posedge mclk);
		wr(8'h88, 8'h00);
		expect4(8'h03, 8'h00, 8'h03, 8'h00, 8'hFF);
		wr(8'h88, 8'hA0);
		#1;
		chk({6'h00, ovf}, 8'h03);
		@(posedge mclk);
		ack_zero <= 1'b1;
		@(posedge mclk);
		ack_zero <= 1'b0;
		ack_one <= 1'b1;
		#1;
		chk({6'h00, ovf}, 8'h02);
		@(posedge mclk);
		ack_one <= 1'b0;
		#1;
		chk({6'h00, ovf}, 8'h00);
		conclude();
	end
	// hang guard
	initial begin
		repeat (5000) @(posedge mclk);
		failures++;
		conclude();
	end
endmodule
`default_nettype wire
